// >>> hw/camr_pkg.sv
// camr_pkg: shared constants for the lookup register set and array
package camr_pkg;
  localparam int          DATA_W       = 32;
  localparam int          ADDR_W       = 12;
  localparam int          DEPTH        = 4096;
  localparam int          NUM_MASKS    = 7;
  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int          OP_HI        = 11;
  localparam int          OP_LO        = 8;
  localparam int          MSEL_HI      = 6;
  localparam int          MSEL_LO      = 4;
  localparam int          CMP_DQ_BIT   = 7;
  localparam int          SW_WR_BIT    = 12;
  localparam logic [3:0]  OP_NOP       = 4'h0;
  localparam logic [3:0]  OP_REG       = 4'h1;
  localparam logic [3:0]  OP_MEM_AR    = 4'h2;
  localparam logic [3:0]  OP_MEM_NF    = 4'h3;
  localparam logic [3:0]  OP_CMP       = 4'h4;
  localparam logic [3:0]  OP_AR_INC    = 4'h5;
  localparam logic [3:0]  OP_AR_DEC    = 4'h6;
  localparam logic [3:0]  OP_VALID     = 4'h7;
  localparam logic [3:0]  OP_VP        = 4'h8;
  localparam logic [1:0]  AUTO_INC     = 2'h1;
  localparam logic [1:0]  AUTO_DEC     = 2'h2;
  // ----------------------------------------------------------------
  // register indices for register cycles
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_COMPARE  = 4'h0;
  localparam logic [3:0]  REG_ADDR     = 4'h8;
  localparam logic [3:0]  REG_CONFIG   = 4'h9;
  localparam logic [3:0]  REG_STATUS   = 4'hA;
  localparam logic [3:0]  REG_NEXTFREE = 4'hB;
  localparam logic [3:0]  REG_SELECT   = 4'hC;
  localparam logic [3:0]  REG_COMMAND  = 4'hD;
  // ----------------------------------------------------------------
  // config, select and status fields
  // ----------------------------------------------------------------
  localparam int          CFG_WMASK_HI = 31;
  localparam int          CFG_WMASK_LO = 29;
  localparam int          CFG_MODE_HI  = 27;
  localparam int          CFG_MODE_LO  = 26;
  localparam int          CFG_LOWEST   = 25;
  localparam int          CFG_VP_DIS   = 24;
  localparam int          CFG_VPMSK_HI = 23;
  localparam int          CFG_VPMSK_LO = 12;
  localparam int          CFG_VPPG_HI  = 7;
  localparam int          CFG_VPPG_LO  = 4;
  localparam int          CFG_PAGE_HI  = 3;
  localparam int          CFG_PAGE_LO  = 0;
  localparam logic [1:0]  MODE_SW      = 2'h1;
  localparam int          DS_DIS_BIT   = 8;
  localparam logic [1:0]  RES_MATCH    = 2'h0;
  localparam logic [1:0]  RES_MEM      = 2'h1;
  localparam logic [1:0]  RES_VP       = 2'h2;
  localparam logic [1:0]  RES_RESET    = 2'h3;
  localparam logic [31:0] RST_CONFIG   = 32'h0000_0000;
  localparam logic [31:0] RST_SELECT   = 32'h0000_0100;
endpackage

// >>> hw/camr_sync.sv
// camr_sync: two-flop synchroniser for a group of pin inputs
module camr_sync #(
  parameter int               W   = 1,
  parameter logic [W-1:0]     RST = '1
) (
  input  wire logic           sys_clk,
  input  wire logic           rstn,
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } camr_sync_s;

  camr_sync_s st_reg;
  camr_sync_s st_next;

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{s1: RST, s2: RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule

// >>> hw/camr_array.sv
// camr_array: content array with validity bits, compare and free search
module camr_array
  import camr_pkg::*;
#(
  parameter int               DW = camr_pkg::DATA_W,
  parameter int               AW = camr_pkg::ADDR_W,
  parameter int               N  = camr_pkg::DEPTH
) (
  input  wire logic           sys_clk,
  input  wire logic           rstn,
  input  wire logic           wr_en,
  input  wire logic           vb_en,
  input  wire logic [AW-1:0]  wr_addr,
  input  wire logic [DW-1:0]  wr_data,
  input  wire logic [DW-1:0]  wr_keep,
  input  wire logic           wr_empty,
  input  wire logic [AW-1:0]  rd_addr,
  output logic      [DW-1:0]  rd_data,
  output logic                rd_empty,
  input  wire logic [DW-1:0]  cmp_key,
  input  wire logic [DW-1:0]  cmp_mask,
  output logic                hit,
  output logic                multi,
  output logic      [AW-1:0]  hit_addr,
  output logic      [AW-1:0]  free_addr,
  output logic                full
);
  typedef struct packed {
    logic [N-1:0][DW-1:0] data;
    logic [N-1:0]         empty;
  } camr_array_s;

  camr_array_s st_reg;
  camr_array_s st_next;
  logic [N-1:0] match;

  // lowest index wins, location zero has top priority
  function automatic logic [AW-1:0] first_set(input logic [N-1:0] v);
    logic [AW-1:0] r;
    r = '1;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = AW'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    st_next = st_reg;
    hit     = 1'b0;
    multi   = 1'b0;
    for (int i = 0; i < N; i++) begin
      match[i] = !st_reg.empty[i] && (((st_reg.data[i] ^ cmp_key) & ~cmp_mask) == '0);
      multi    = multi | (hit & match[i]);
      hit      = hit | match[i];
    end
    hit_addr  = first_set(match);
    free_addr = first_set(st_reg.empty);
    full      = ~|st_reg.empty;
    rd_data   = st_reg.data[rd_addr];
    rd_empty  = st_reg.empty[rd_addr];
    if (wr_en) begin
      st_next.data[wr_addr] = (st_reg.data[wr_addr] & wr_keep) | (wr_data & ~wr_keep);
    end
    if (vb_en) begin
      st_next.empty[wr_addr] = wr_empty;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{data: '0, empty: '1};
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// >>> hw/camr_top.sv
// camr_top: register set, command execution, path table and selection
//
// Behaviour
// - mask bit zero compares or writes; one excludes and keeps stored bit
// - indirect address holds twelve address bits; upper twenty kept zero
// - commands step the indirect address; accesses may auto step after use
// - three config bits pick mask for direct writes; zero means unmasked
// - two config bits choose pin control or command register control
// - config bits mark lowest priority device and disable the path table
// - config holds path mask, path page and device page fields
// - status top bit low on array match or path table hit
// - status array match bit low only on array match
// - status multi match bit low when this device matches twice or more
// - full bit low only when all valid and full chain input low
// - status holds result type, page and active address of latest change
// - next free register holds highest priority empty location and page
// - select register selects on page equality when its disable bit low
// - command register low twelve bits run the same control operations
// - 4096 words, location zero highest; free writes fill upward from zero
// - empty locations are skipped in compares
// - validity pin loads on random access writes, drives on reads, feeds free search
// - random access by direct pin address or indirect address register
// - 4K x 1 path table indexed by masked upper key bits; zero is hit
// - array match beats table hit; hit shows masked index and path page
// - selected by select register or either select pin at cycle start
module camr_top
  import camr_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  input  wire logic                         cycle_n,
  input  wire logic                         write_n,
  input  wire logic                         direct_addr_valid_n,
  input  wire logic [camr_pkg::ADDR_W-1:0]  control_bus,
  input  wire logic [camr_pkg::DATA_W-1:0]  dq_in,
  output logic      [camr_pkg::DATA_W-1:0]  dq_out,
  output logic                              dq_oe,
  input  wire logic                         validity_pin_n_in,
  output logic                              validity_pin_n_out,
  output logic                              validity_pin_n_oe,
  input  wire logic                         global_select_n,
  input  wire logic                         local_select_n,
  input  wire logic                         full_chain_in_n,
  input  wire logic                         out_enable_n,
  output logic      [camr_pkg::ADDR_W-1:0]  active_addr_lines,
  output logic      [3:0]                   page_lines,
  output logic                              addr_oe,
  output logic                              match_valid_n,
  output logic                              array_match_n,
  output logic                              multi_match_n,
  output logic                              full_out_n
);
  import camr_pkg::*;

  localparam int PIN_W = 8 + ADDR_W + DATA_W;

  typedef struct packed {
    logic [DATA_W-1:0]                 comparand;
    logic [NUM_MASKS-1:0][DATA_W-1:0]  masks;
    logic [DATA_W-1:0]                 addr;
    logic [DATA_W-1:0]                 cfg;
    logic [DATA_W-1:0]                 dsel;
    logic [DATA_W-1:0]                 cmd;
    logic [ADDR_W-1:0]                 aa;
    logic [3:0]                        pa;
    logic [1:0]                        rtype;
    logic                              aa_act;
    logic                              mv_n;
    logic                              mf_n;
    logic                              mm_n;
    logic                              ff_n;
    logic [DATA_W-1:0]                 dq;
    logic                              dq_oe;
    logic                              vb_oe;
    logic                              vb;
    logic                              e_prev;
  } camr_state_s;

  camr_state_s        st_reg;
  camr_state_s        st_next;
  logic [PIN_W-1:0]   pins_s;
  logic               e_n_s;
  logic               w_n_s;
  logic               av_n_s;
  logic               vb_n_s;
  logic               gsel_s;
  logic               lsel_s;
  logic               fi_s;
  logic               oe_s;
  logic [ADDR_W-1:0]  cb_s;
  logic [DATA_W-1:0]  dq_s;
  logic               path_tbl [DEPTH];
  logic               vp_we;
  logic [ADDR_W-1:0]  vp_idx;
  logic               vp_d;
  logic               arr_we;
  logic               arr_vbe;
  logic [ADDR_W-1:0]  arr_addr;
  logic [DATA_W-1:0]  arr_keep;
  logic               arr_empty;
  logic [DATA_W-1:0]  cmp_key;
  logic [DATA_W-1:0]  cmp_mask;
  logic [DATA_W-1:0]  rd_data;
  logic               rd_empty;
  logic               hit;
  logic               multi;
  logic [ADDR_W-1:0]  hit_addr;
  logic [ADDR_W-1:0]  free_addr;
  logic               full;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  camr_sync #(
    .W   (PIN_W),
    .RST ({8'hFF, {(ADDR_W + DATA_W){1'b0}}})
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d       ({cycle_n, write_n, direct_addr_valid_n, validity_pin_n_in, global_select_n,
               local_select_n, full_chain_in_n, out_enable_n, control_bus, dq_in}),
    .q       (pins_s)
  );

  assign {e_n_s, w_n_s, av_n_s, vb_n_s, gsel_s, lsel_s, fi_s, oe_s, cb_s, dq_s} = pins_s;

  // ----------------------------------------------------------------
  // content array
  // ----------------------------------------------------------------
  camr_array u_array (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .wr_en     (arr_we),
    .vb_en     (arr_vbe),
    .wr_addr   (arr_addr),
    .wr_data   (dq_s),
    .wr_keep   (arr_keep),
    .wr_empty  (arr_empty),
    .rd_addr   (arr_addr),
    .rd_data   (rd_data),
    .rd_empty  (rd_empty),
    .cmp_key   (cmp_key),
    .cmp_mask  (cmp_mask),
    .hit       (hit),
    .multi     (multi),
    .hit_addr  (hit_addr),
    .free_addr (free_addr),
    .full      (full)
  );

  // select value zero means no mask
  function automatic logic [DATA_W-1:0] mask_of(input camr_state_s s, input logic [2:0] sel);
    logic [DATA_W-1:0] m;
    m = '0;
    if (sel != 3'h0) begin
      m = s.masks[sel - 3'h1];
    end
    return m;
  endfunction

  // register, array and path table accesses wait for a later cycle in command mode; compares run at once
  function automatic logic needs_data(input logic [ADDR_W-1:0] c);
    logic [3:0] op;
    op = c[OP_HI:OP_LO];
    return (op == OP_REG) || (op == OP_MEM_AR) || (op == OP_MEM_NF) || (op == OP_VP);
  endfunction

  function automatic logic [DATA_W-1:0] status_word(input camr_state_s s);
    logic [DATA_W-1:0] r;
    r        = '0;
    r[31]    = s.mv_n;
    r[30]    = s.mf_n;
    r[29]    = s.mm_n;
    r[28]    = s.ff_n;
    r[25:24] = s.rtype;
    r[19:16] = s.pa;
    r[11:0]  = s.aa;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // cycle execution
  // ----------------------------------------------------------------
  always_comb begin
    logic              start;
    logic              sel;
    logic              lowest;
    logic              run;
    logic              wr;
    logic              direct;
    logic [ADDR_W-1:0] c;
    logic [3:0]        op;
    logic [3:0]        ridx;
    logic              vp_hit;
    logic [ADDR_W-1:0] vidx;
    start    = 1'b0;
    sel      = 1'b0;
    lowest   = 1'b0;
    run      = 1'b0;
    wr       = 1'b0;
    direct   = 1'b0;
    c        = '0;
    op       = OP_NOP;
    ridx     = '0;
    vp_hit   = 1'b0;
    vidx     = '0;
    st_next  = st_reg;
    vp_we    = 1'b0;
    vp_idx   = st_reg.addr[ADDR_W-1:0];
    vp_d     = dq_s[0];
    arr_we   = 1'b0;
    arr_vbe  = 1'b0;
    arr_addr = st_reg.addr[ADDR_W-1:0];
    arr_keep = '0;
    arr_empty = vb_n_s;
    cmp_key  = st_reg.comparand;
    cmp_mask = '0;

    start          = st_reg.e_prev & ~e_n_s;
    st_next.e_prev = e_n_s;
    lowest         = st_reg.cfg[CFG_LOWEST];
    sel = ~gsel_s | ~lsel_s | (~st_reg.dsel[DS_DIS_BIT] &&
          st_reg.dsel[3:0] == st_reg.cfg[CFG_PAGE_HI:CFG_PAGE_LO]);
    st_next.ff_n  = ~(full & ~fi_s);
    st_next.dq_oe = st_reg.dq_oe & ~e_n_s;
    st_next.vb_oe = st_reg.vb_oe & ~e_n_s;

    if (start && sel) begin
      if (st_reg.cfg[CFG_MODE_HI:CFG_MODE_LO] == MODE_SW) begin
        if (!av_n_s) begin
          c   = st_reg.cmd[ADDR_W-1:0];
          run = 1'b1;
          wr  = ~w_n_s;
        end else if (!w_n_s) begin
          st_next.cmd = {{(DATA_W-ADDR_W){1'b0}}, dq_s[ADDR_W-1:0]};
          c   = dq_s[ADDR_W-1:0];
          run = !needs_data(dq_s[ADDR_W-1:0]);
          wr  = ~dq_s[SW_WR_BIT];
        end else begin
          st_next.dq    = status_word(st_reg);
          st_next.dq_oe = 1'b1;
        end
      end else if (!av_n_s) begin
        direct = 1'b1;
        run    = 1'b1;
        wr     = ~w_n_s;
      end else begin
        c   = cb_s;
        run = 1'b1;
        wr  = ~w_n_s;
      end
    end

    op   = direct ? OP_MEM_AR : c[OP_HI:OP_LO];
    ridx = c[3:0];
    if (run) begin
      case (op)
        OP_REG: begin
          if (wr) begin
            if (ridx == REG_COMPARE) begin
              st_next.comparand = dq_s;
            end else if (ridx <= 4'(NUM_MASKS)) begin
              st_next.masks[ridx - 4'h1] = dq_s;
            end else if (ridx == REG_ADDR) begin
              st_next.addr = {{(DATA_W-ADDR_W){1'b0}}, dq_s[ADDR_W-1:0]};
            end else if (ridx == REG_CONFIG) begin
              st_next.cfg = dq_s & 32'hEFFF_F0FF;
            end else if (ridx == REG_SELECT) begin
              st_next.dsel = dq_s;
            end else if (ridx == REG_COMMAND) begin
              st_next.cmd = dq_s;
            end
          end else begin
            st_next.dq_oe = 1'b1;
            if (ridx == REG_COMPARE) begin
              st_next.dq = st_reg.comparand;
            end else if (ridx <= 4'(NUM_MASKS)) begin
              st_next.dq = st_reg.masks[ridx - 4'h1];
            end else if (ridx == REG_ADDR) begin
              st_next.dq = st_reg.addr;
            end else if (ridx == REG_CONFIG) begin
              st_next.dq = st_reg.cfg;
            end else if (ridx == REG_STATUS) begin
              st_next.dq = status_word(st_reg);
            end else if (ridx == REG_NEXTFREE) begin
              st_next.dq = {12'h000, st_reg.cfg[CFG_PAGE_HI:CFG_PAGE_LO], 4'h0, free_addr};
            end else if (ridx == REG_SELECT) begin
              st_next.dq = st_reg.dsel;
            end else begin
              st_next.dq = '0;
            end
          end
        end
        OP_MEM_AR: begin
          if (direct) begin
            arr_addr = cb_s;
            arr_keep = mask_of(st_reg, st_reg.cfg[CFG_WMASK_HI:CFG_WMASK_LO]);
          end else begin
            arr_keep = mask_of(st_reg, c[MSEL_HI:MSEL_LO]);
            if (c[1:0] == AUTO_INC) begin
              st_next.addr = {{(DATA_W-ADDR_W){1'b0}}, st_reg.addr[ADDR_W-1:0] + 12'h001};
            end else if (c[1:0] == AUTO_DEC) begin
              st_next.addr = {{(DATA_W-ADDR_W){1'b0}}, st_reg.addr[ADDR_W-1:0] - 12'h001};
            end
          end
          arr_we  = wr;
          arr_vbe = wr;
          if (!wr) begin
            st_next.dq    = rd_data;
            st_next.dq_oe = 1'b1;
            st_next.vb    = rd_empty;
            st_next.vb_oe = 1'b1;
          end
          st_next.aa     = arr_addr;
          st_next.pa     = st_reg.cfg[CFG_PAGE_HI:CFG_PAGE_LO];
          st_next.rtype  = RES_MEM;
          st_next.aa_act = 1'b1;
        end
        OP_MEM_NF: begin
          st_next.rtype = RES_MEM;
          if (!fi_s && !full) begin
            arr_addr       = free_addr;
            arr_keep       = mask_of(st_reg, c[MSEL_HI:MSEL_LO]);
            arr_we         = 1'b1;
            arr_vbe        = 1'b1;
            arr_empty      = 1'b0;
            st_next.aa     = free_addr;
            st_next.pa     = st_reg.cfg[CFG_PAGE_HI:CFG_PAGE_LO];
            st_next.aa_act = 1'b1;
          end else begin
            st_next.aa     = '1;
            st_next.pa     = '1;
            st_next.aa_act = lowest;
          end
        end
        OP_CMP: begin
          if (c[CMP_DQ_BIT]) begin
            cmp_key           = dq_s;
            st_next.comparand = dq_s;
          end
          cmp_mask = mask_of(st_reg, c[MSEL_HI:MSEL_LO]);
          vidx     = cmp_key[DATA_W-1:DATA_W-ADDR_W] & ~st_reg.cfg[CFG_VPMSK_HI:CFG_VPMSK_LO];
          vp_hit   = lowest & ~st_reg.cfg[CFG_VP_DIS] & ~path_tbl[vidx];
          st_next.mf_n  = ~hit;
          st_next.mv_n  = ~(hit | vp_hit);
          st_next.mm_n  = ~multi;
          st_next.rtype = vp_hit && !hit ? RES_VP : RES_MATCH;
          if (hit) begin
            st_next.aa     = hit_addr;
            st_next.pa     = st_reg.cfg[CFG_PAGE_HI:CFG_PAGE_LO];
            st_next.aa_act = 1'b1;
          end else if (vp_hit) begin
            st_next.aa     = vidx;
            st_next.pa     = st_reg.cfg[CFG_VPPG_HI:CFG_VPPG_LO];
            st_next.aa_act = 1'b1;
          end else begin
            st_next.aa     = '1;
            st_next.pa     = '1;
            st_next.aa_act = lowest;
          end
        end
        OP_AR_INC: begin
          st_next.addr = {{(DATA_W-ADDR_W){1'b0}}, st_reg.addr[ADDR_W-1:0] + 12'h001};
        end
        OP_AR_DEC: begin
          st_next.addr = {{(DATA_W-ADDR_W){1'b0}}, st_reg.addr[ADDR_W-1:0] - 12'h001};
        end
        OP_VALID: begin
          arr_vbe   = 1'b1;
          arr_empty = c[0];
        end
        OP_VP: begin
          vp_we = wr & lowest;
          if (c[1:0] == AUTO_INC) begin
            st_next.addr = {{(DATA_W-ADDR_W){1'b0}}, st_reg.addr[ADDR_W-1:0] + 12'h001};
          end
          if (!wr) begin
            st_next.dq    = {31'h0000_0000, path_tbl[vp_idx]};
            st_next.dq_oe = lowest;
          end
          st_next.aa     = vp_idx;
          st_next.pa     = st_reg.cfg[CFG_VPPG_HI:CFG_VPPG_LO];
          st_next.rtype  = RES_VP;
          st_next.aa_act = lowest;
        end
        default: begin
          st_next.e_prev = e_n_s;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{comparand: '0, masks: '0, addr: '0, cfg: RST_CONFIG, dsel: RST_SELECT, cmd: '0,
                  aa: '1, pa: '1, rtype: RES_RESET, aa_act: 1'b0, mv_n: 1'b1, mf_n: 1'b1,
                  mm_n: 1'b1, ff_n: 1'b1, dq: '0, dq_oe: 1'b0, vb_oe: 1'b0, vb: 1'b1, e_prev: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // path table: no reset so contents survive any reset
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (vp_we) begin
      path_tbl[vp_idx] <= vp_d;
    end
  end

  assign dq_out             = st_reg.dq;
  assign dq_oe              = st_reg.dq_oe;
  assign validity_pin_n_out = st_reg.vb;
  assign validity_pin_n_oe  = st_reg.vb_oe;
  assign active_addr_lines  = st_reg.aa;
  assign page_lines         = st_reg.pa;
  assign addr_oe            = st_reg.aa_act & ~oe_s;
  assign match_valid_n      = st_reg.mv_n;
  assign array_match_n      = st_reg.mf_n;
  assign multi_match_n      = st_reg.mm_n;
  assign full_out_n         = st_reg.ff_n;
endmodule

// >>> test/camr_host.sv
// host controller model running one bus cycle at a time
module camr_host (
  input  wire logic        sys_clk,
  input  wire logic [31:0] dq_out,
  input  wire logic        dq_oe,
  output logic             cycle_n,
  output logic             write_n,
  output logic             direct_addr_valid_n,
  output logic      [11:0] control_bus,
  output logic      [31:0] dq_in,
  output logic             validity_pin_n_in,
  output logic             global_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cycle_n, write_n, direct_addr_valid_n, global_select_n, control_bus, dq_in} = '1;
  assign validity_pin_n_in = 1'b0; // writes mark the location valid
  task automatic xfer(input logic wn, av, sel, input logic [11:0] cb, input logic [31:0] d,
                      output logic [31:0] q);
    @(negedge sys_clk);
    {write_n, direct_addr_valid_n, global_select_n, control_bus, dq_in} = {wn, av, sel, cb, d};
    cycle_n = 0;
    repeat (4) @(negedge sys_clk);
    q = dq_oe ? dq_out : 32'hz;
    cycle_n = 1; // strobe low four cycles, high five before the next cycle
    repeat (4) @(negedge sys_clk);
    {global_select_n, dq_in} = {1'b1, ~d}; // a released bus does not keep its last value
  endtask
endmodule

// >>> test/camr_props.sv
// pin-level checks for the lookup device
module camr_props (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        cycle_n,
  input wire logic        full_chain_in_n,
  input wire logic        out_enable_n,
  input wire logic [11:0] active_addr_lines,
  input wire logic [3:0]  page_lines,
  input wire logic        addr_oe,
  input wire logic        dq_oe,
  input wire logic        match_valid_n,
  input wire logic        array_match_n,
  input wire logic        multi_match_n,
  input wire logic        full_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  property p_mv; !array_match_n |-> !match_valid_n; endproperty
  a_mv: assert property (p_mv) else $error("valid flag high");
  property p_mm; !multi_match_n |-> !array_match_n; endproperty
  a_mm: assert property (p_mm) else $error("multi without match");
  property p_full; full_chain_in_n [*5] |-> full_out_n; endproperty
  a_full: assert property (p_full) else $error("full with chain high");
  property p_rst; $rose(rstn) |-> active_addr_lines == 12'hFFF && page_lines == 4'hF; endproperty
  a_rst: assert property (p_rst) else $error("reset address");
  property p_hold; cycle_n [*5] |=> $stable(active_addr_lines) && $stable(page_lines); endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_flags; cycle_n [*5] |=> $stable({match_valid_n, array_match_n, multi_match_n}); endproperty
  a_flags: assert property (p_flags) else $error("flags moved");
  property p_aoe; out_enable_n [*4] |-> !addr_oe; endproperty
  a_aoe: assert property (p_aoe) else $error("address driven");
  property p_dq; cycle_n [*4] |-> !dq_oe; endproperty
  a_dq: assert property (p_dq) else $error("data driven idle");
  c_multi: cover property (!multi_match_n);
  c_path: cover property (!match_valid_n && array_match_n);
  c_full: cover property (!full_out_n);
endmodule
bind camr_top camr_props camr_props_inst (.*);

// >>> test/camr_top_test.sv
// self-checking bench for the lookup register set
module camr_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rstn = 0, full_chain_in_n = 0, out_enable_n = 0, local_select_n = 1;
  logic        vb_n_out, vb_n_oe;
  logic        cycle_n, write_n, direct_addr_valid_n, validity_pin_n_in, global_select_n;
  logic        dq_oe, addr_oe, match_valid_n, array_match_n, multi_match_n, full_out_n;
  logic [11:0] control_bus, active_addr_lines;
  logic [31:0] dq_in, dq_out, q;
  logic [3:0]  page_lines;
  int          mismatches = 0, n_tests = 0;
  camr_host camr_host_inst (.*);
  camr_top camr_top_inst (.*, .validity_pin_n_out(vb_n_out), .validity_pin_n_oe(vb_n_oe));
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] cb, input logic [31:0] d, input logic av = 1);
    camr_host_inst.xfer(0, av, 0, cb, d, q);
  endtask
  task automatic rd(input logic [11:0] cb, input logic [31:0] exp, input logic sel = 0);
    camr_host_inst.xfer(1, 1, sel, cb, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #700_000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rstn = 1;
    rd(12'h109, 32'h0);
    rd(12'h10C, 32'h100);
    rd(12'h10A, 32'hF30F_0FFF);
    wr(12'h109, 32'hFFFF_FFFF);
    rd(12'h109, 32'hEFFF_F0FF);
    for (int i = 0; i < 4096; i++) wr(12'h801, 32'h1);
    wr(12'h109, 32'h0200_0053);
    wr(12'h108, 32'h5);
    wr(12'h500, 32'h0);
    wr(12'h600, 32'h0);
    wr(12'h600, 32'h0);
    wr(12'h201, 32'hAAAA_5555);
    rd(12'h108, 32'h5);
    wr(12'h007, 32'hAAAA_5555, 0);
    wr(12'h480, 32'hAAAA_5555);
    rd(12'h10A, 32'h1003_0004);
    chk(32'({addr_oe, page_lines, active_addr_lines}), 32'h1_3004);
    out_enable_n = 1;
    repeat (4) @(negedge sys_clk);
    out_enable_n = 0;
    wr(12'h101, 32'hFFFF);
    wr(12'h600, 32'h0);
    wr(12'h210, 32'h1234_9876);
    rd(12'h200, 32'h1234_5555);
    chk(32'({vb_n_oe, vb_n_out}), 32'h0);
    wr(12'h701, 32'h0);
    wr(12'h480, 32'hAAAA_5555);
    rd(12'h10A, 32'h3003_0007);
    rd(12'h10B, 32'h3_0000);
    wr(12'h108, 32'hAB);
    wr(12'h800, 32'h0);
    wr(12'h480, 32'h0AB0_0000);
    rd(12'h10A, 32'h7205_00AB);
    camr_host_inst.xfer(0, 1, 1, 12'h108, 32'h77, q);
    local_select_n = 0;
    rd(12'h108, 32'hAB, 1);
    local_select_n = 1;
    wr(12'h10C, 32'h3);
    rd(12'h109, 32'h0200_0053, 1);
    for (int i = 0; i < 4095; i++) wr(12'h300, 32'(i));
    chk(32'(full_out_n), 32'h0);
    rd(12'h10B, 32'h3_0FFF);
    wr(12'h300, 32'h0);
    chk(32'({page_lines, active_addr_lines}), 32'hFFFF);
    full_chain_in_n = 1;
    repeat (5) @(negedge sys_clk);
    chk(32'(full_out_n), 32'h1);
    wr(12'h109, 32'h0600_0053);
    rd(12'h000, 32'h710F_0FFF);
    wr(12'h000, 32'h108);
    wr(12'h000, 32'h5A, 0);
    camr_host_inst.xfer(1, 0, 0, 12'h000, 32'h0, q);
    chk(q, 32'h5A);
    report_and_stop();
  end
endmodule
